//--- core/timer8_pkg.sv
// Constants and register map of the 8-bit timer with two compare channels
// Operation
// - Three-bit wave mode from two registers
// - Mode 000 counts to 0xFF, immediate
// - Mode 001 counts up/down, overflow at bottom
// - Mode 011 fast PWM, latch at bottom
// - Mode 101 phase-correct, compare A top
// - Mode 111 fast PWM, overflow at top
// - Force bits cause immediate match, non-PWM
// - Forced match: no flag, no clear
// - Force bits read zero, ignored in PWM
// - Control B bits 5:4 read zero
// - Clock select: stop, undivided, prescaled
// - Count register readable and writable live
// - Count write blocks match next tick
// - Both compare registers compared continuously
// - Interrupt needs enable, global enable, flag
// - Compare flags set on match, clearable
// - Overflow flag set, clearable
// - Timer clock selectable: bus clock or pin
package timer8_pkg;

    localparam int         ADDR_W        = 12;
    localparam int         DATA_W        = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_A    = 8'hb0;
    localparam logic [7:0] IDX_CTRL_B    = 8'hb1;
    localparam logic [7:0] IDX_COUNT     = 8'hb2;
    localparam logic [7:0] IDX_CMP_A     = 8'hb3;
    localparam logic [7:0] IDX_CMP_B     = 8'hb4;
    localparam logic [7:0] IDX_CLK_SRC   = 8'hb6;
    localparam logic [7:0] IDX_IRQ_EN    = 8'hb8;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'hb9;

    // Field positions
    localparam int         FORCE_A_BIT   = 7;
    localparam int         FORCE_B_BIT   = 6;
    localparam int         WGM_HIGH_BIT  = 3;
    localparam int         ASYNC_SEL_BIT = 5;
    localparam int         OVF_BIT       = 0;
    localparam int         CMPA_BIT      = 1;
    localparam int         CMPB_BIT      = 2;

    localparam logic [7:0] COUNT_MAX     = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM  = 8'h00;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    localparam int         PSC_W         = 10;

    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    typedef enum logic [2:0] {
        WM_NORMAL, WM_PHASE_FF, WM_CTC, WM_FAST_FF,
        WM_RSVD4, WM_PHASE_A, WM_RSVD6, WM_FAST_A
    } wave_mode_e;

endpackage

//--- core/timer8_wavegen.sv
// Timer/counter core with AXI4-Lite register slave and two waveform outputs
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module timer8_wavegen
    import timer8_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              global_irq_enable,
    input  wire logic              vector_ack_overflow,
    input  wire logic              vector_ack_compare_a,
    input  wire logic              vector_ack_compare_b,
    input  wire logic              timer_source_clock,
    output logic                   wave_out_a,
    output logic                   wave_out_b,
    output logic                   irq_overflow,
    output logic                   irq_compare_a,
    output logic                   irq_compare_b
);

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              arready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [7:0]        rdata;
        logic [7:0]        rd_idx;
        logic [ADDR_W-1:0] aw_addr;
        logic [7:0]        w_data;
        logic              w_lane0;
        logic [1:0]        output_mode_a;
        logic [1:0]        output_mode_b;
        logic [1:0]        wave_mode_low_bits;
        logic              wave_mode_high_bit;
        logic [2:0]        clock_select_field;
        logic              async_clock_select;
        logic [7:0]        count;
        logic [7:0]        cmp_a_buf;
        logic [7:0]        cmp_b_buf;
        logic [7:0]        cmp_a;
        logic [7:0]        cmp_b;
        logic [2:0]        irq_en;
        logic [2:0]        flags;
        logic [2:0]        pin_sync;
        logic [PSC_W-1:0]  psc;
        logic              down;
        logic              block;
        logic              wave_a;
        logic              wave_b;
        logic              irq_ovf;
        logic              irq_a;
        logic              irq_b;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // Low bits of the prescaler that must all be one for a tick
    function automatic logic [PSC_W-1:0] presc_mask(input logic [2:0] cs);
        case (cs)
            3'h2:    presc_mask = 10'h007;
            3'h3:    presc_mask = 10'h01f;
            3'h4:    presc_mask = 10'h03f;
            3'h5:    presc_mask = 10'h07f;
            3'h6:    presc_mask = 10'h0ff;
            3'h7:    presc_mask = 10'h3ff;
            default: presc_mask = 10'h000;
        endcase
    endfunction

    // Next pin level of one channel from its output mode and events
    function automatic logic wave_next(
        input logic       cur,
        input logic [1:0] com,
        input logic       hit,
        input logic       bot,
        input logic       pwm,
        input logic       phase,
        input logic       up,
        input logic       tog_ok
    );
        logic r;
        r = cur;
        if (!pwm) begin
            if (hit) begin
                case (com)
                    2'h1:    r = ~cur;
                    2'h2:    r = 1'b0;
                    2'h3:    r = 1'b1;
                    default: r = cur;
                endcase
            end
        end else if (com == 2'h1) begin
            if (hit && tog_ok) begin
                r = ~cur;
            end
        end else if (com[1]) begin
            if (phase) begin
                if (hit) begin
                    r = up ? com[0] : ~com[0];
                end
            end else if (hit) begin
                r = com[0];
            end else if (bot) begin
                r = ~com[0];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    wave_mode_e mode;
    logic       pwm;
    logic       phase;
    logic [7:0] top;
    logic       src_tick;
    logic       tick;
    logic       at_top;
    logic       match_a;
    logic       match_b;
    logic       force_a;
    logic       force_b;
    logic       wr_fire;
    logic [7:0] wr_idx;
    logic       wr_ok;
    logic       wr_en;
    logic       cnt_wr;
    logic [7:0] ar_idx;
    logic       ar_ok;
    logic [2:0] set_flags;
    logic [2:0] clr_flags;
    logic       ovf_event;
    logic       wrap;
    logic       update_cmp;

    always_comb begin
        nxt_st = st_ff;
        mode  = wave_mode_e'({st_ff.wave_mode_high_bit, st_ff.wave_mode_low_bits});
        pwm   = st_ff.wave_mode_low_bits[0];
        phase = (mode == WM_PHASE_FF) || (mode == WM_PHASE_A);
        top   = (mode == WM_CTC || mode == WM_PHASE_A || mode == WM_FAST_A)
              ? st_ff.cmp_a : COUNT_MAX;

        // Timer clock: every bus cycle, or each rising edge of the pin
        nxt_st.pin_sync = {st_ff.pin_sync[1:0], timer_source_clock};
        src_tick = st_ff.async_clock_select
                 ? (st_ff.pin_sync[1] && !st_ff.pin_sync[2]) : 1'b1;
        tick = src_tick && (st_ff.clock_select_field != 3'h0)
            && ((st_ff.psc & presc_mask(st_ff.clock_select_field))
                == presc_mask(st_ff.clock_select_field));
        if (src_tick) begin
            nxt_st.psc = st_ff.psc + 10'h001;
        end

        // Register write: address and data taken in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_addr = s_axi_awaddr;
            nxt_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_data  = s_axi_wdata[7:0];
            nxt_st.w_lane0 = s_axi_wstrb[0];
            nxt_st.wready  = 1'b0;
        end
        wr_fire = !st_ff.awready && !st_ff.wready && !st_ff.bvalid;
        wr_idx  = st_ff.aw_addr[9:2];
        wr_ok   = (st_ff.aw_addr[ADDR_W-1:10] == '0)
               && (wr_idx == IDX_CTRL_A || wr_idx == IDX_CTRL_B || wr_idx == IDX_COUNT
                || wr_idx == IDX_CMP_A || wr_idx == IDX_CMP_B || wr_idx == IDX_CLK_SRC
                || wr_idx == IDX_IRQ_EN || wr_idx == IDX_IRQ_FLAGS);
        wr_en   = wr_fire && wr_ok && st_ff.w_lane0;
        cnt_wr  = wr_en && (wr_idx == IDX_COUNT);
        force_a = wr_en && (wr_idx == IDX_CTRL_B) && st_ff.w_data[FORCE_A_BIT] && !pwm;
        force_b = wr_en && (wr_idx == IDX_CTRL_B) && st_ff.w_data[FORCE_B_BIT] && !pwm;
        clr_flags = {vector_ack_compare_b, vector_ack_compare_a, vector_ack_overflow};
        if (wr_fire) begin
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
            nxt_st.awready = 1'b1;
            nxt_st.wready  = 1'b1;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (wr_en) begin
            case (wr_idx)
                IDX_CTRL_A: begin
                    nxt_st.output_mode_a      = st_ff.w_data[7:6];
                    nxt_st.output_mode_b      = st_ff.w_data[5:4];
                    nxt_st.wave_mode_low_bits = st_ff.w_data[1:0];
                end
                IDX_CTRL_B: begin
                    nxt_st.wave_mode_high_bit = st_ff.w_data[WGM_HIGH_BIT];
                    nxt_st.clock_select_field = st_ff.w_data[2:0];
                end
                IDX_CMP_A:     nxt_st.cmp_a_buf = st_ff.w_data;
                IDX_CMP_B:     nxt_st.cmp_b_buf = st_ff.w_data;
                IDX_CLK_SRC:   nxt_st.async_clock_select = st_ff.w_data[ASYNC_SEL_BIT];
                IDX_IRQ_EN:    nxt_st.irq_en = st_ff.w_data[2:0];
                IDX_IRQ_FLAGS: clr_flags = clr_flags | st_ff.w_data[2:0];
                default:       nxt_st.bresp = nxt_st.bresp;
            endcase
        end

        // Counter, compare and overflow events on each tick
        at_top    = (st_ff.count == top);
        match_a   = tick && !st_ff.block && (st_ff.count == st_ff.cmp_a);
        match_b   = tick && !st_ff.block && (st_ff.count == st_ff.cmp_b);
        wrap      = tick && !phase && at_top;
        ovf_event = 1'b0;
        update_cmp = 1'b0;
        if (tick) begin
            nxt_st.block = 1'b0;
            if (phase) begin
                if (!st_ff.down) begin
                    if (at_top) begin
                        nxt_st.down  = 1'b1;
                        nxt_st.count = st_ff.count - 8'h01;
                        update_cmp   = 1'b1;
                    end else begin
                        nxt_st.count = st_ff.count + 8'h01;
                    end
                end else if (st_ff.count == COUNT_BOTTOM) begin
                    nxt_st.down  = 1'b0;
                    nxt_st.count = st_ff.count + 8'h01;
                    ovf_event    = 1'b1;
                end else begin
                    nxt_st.count = st_ff.count - 8'h01;
                end
            end else begin
                nxt_st.down  = 1'b0;
                nxt_st.count = at_top ? COUNT_BOTTOM : st_ff.count + 8'h01;
                ovf_event    = (mode == WM_FAST_A) ? at_top : (st_ff.count == COUNT_MAX);
                update_cmp   = pwm && at_top;
            end
        end
        if (!pwm || update_cmp) begin
            nxt_st.cmp_a = nxt_st.cmp_a_buf;
            nxt_st.cmp_b = nxt_st.cmp_b_buf;
        end
        if (cnt_wr) begin
            nxt_st.count = st_ff.w_data;
            nxt_st.block = 1'b1;
        end

        // Set wins over clear; forced matches raise no flag
        set_flags    = {match_b, match_a, ovf_event};
        nxt_st.flags = (st_ff.flags & ~clr_flags) | set_flags;
        nxt_st.irq_ovf = st_ff.flags[OVF_BIT] && st_ff.irq_en[OVF_BIT] && global_irq_enable;
        nxt_st.irq_a = st_ff.flags[CMPA_BIT] && st_ff.irq_en[CMPA_BIT] && global_irq_enable;
        nxt_st.irq_b = st_ff.flags[CMPB_BIT] && st_ff.irq_en[CMPB_BIT] && global_irq_enable;

        nxt_st.wave_a = wave_next(st_ff.wave_a, st_ff.output_mode_a, match_a || force_a,
                                  wrap, pwm, phase, !st_ff.down,
                                  st_ff.wave_mode_high_bit);
        nxt_st.wave_b = wave_next(st_ff.wave_b, st_ff.output_mode_b, match_b || force_b,
                                  wrap, pwm, phase, !st_ff.down, 1'b0);

        // Register read
        ar_idx = s_axi_araddr[9:2];
        ar_ok  = 1'b1;
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid  = 1'b1;
            nxt_st.rd_idx  = ar_idx;
            if (s_axi_araddr[ADDR_W-1:10] != '0) begin
                ar_ok = 1'b0;
            end
            case (ar_idx)
                IDX_CTRL_A: nxt_st.rdata = {st_ff.output_mode_a, st_ff.output_mode_b,
                                            2'h0, st_ff.wave_mode_low_bits};
                IDX_CTRL_B: nxt_st.rdata = {4'h0, st_ff.wave_mode_high_bit,
                                            st_ff.clock_select_field};
                IDX_COUNT:     nxt_st.rdata = st_ff.count;
                IDX_CMP_A:     nxt_st.rdata = st_ff.cmp_a_buf;
                IDX_CMP_B:     nxt_st.rdata = st_ff.cmp_b_buf;
                IDX_CLK_SRC:   nxt_st.rdata = {2'h0, st_ff.async_clock_select, 5'h00};
                IDX_IRQ_EN:    nxt_st.rdata = {5'h00, st_ff.irq_en};
                IDX_IRQ_FLAGS: nxt_st.rdata = {5'h00, st_ff.flags};
                default: begin
                    nxt_st.rdata = RESET_BYTE;
                    ar_ok        = 1'b0;
                end
            endcase
            nxt_st.rresp = ar_ok ? RESP_OKAY : RESP_SLVERR;
            if (!ar_ok) begin
                nxt_st.rdata = RESET_BYTE;
            end
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid  = 1'b0;
            nxt_st.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff         <= '0;
            st_ff.awready <= 1'b1;
            st_ff.wready  <= 1'b1;
            st_ff.arready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready  = st_ff.wready;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rresp   = st_ff.rresp;
    assign s_axi_rdata   = {24'h000000, st_ff.rdata};
    assign wave_out_a    = st_ff.wave_a;
    assign wave_out_b    = st_ff.wave_b;
    assign irq_overflow  = st_ff.irq_ovf;
    assign irq_compare_a = st_ff.irq_a;
    assign irq_compare_b = st_ff.irq_b;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_CTRL_B_HIGH_ZERO: assert property (
        st_ff.rvalid && st_ff.rd_idx == IDX_CTRL_B |-> st_ff.rdata[7:4] == 4'h0)
        else $error("control B upper bits read nonzero");
    AST_STOPPED_HOLDS: assert property (
        st_ff.clock_select_field == 3'h0 && !cnt_wr |=> $stable(st_ff.count))
        else $error("counter moved while stopped");
    AST_DIV8_SPACING: assert property (
        tick && st_ff.clock_select_field == 3'h2 && !st_ff.async_clock_select
        && $stable(st_ff.clock_select_field) |=> !tick [*7])
        else $error("divide by eight ticked early");
    AST_NORMAL_OVERFLOW: assert property (
        tick && mode == WM_NORMAL && st_ff.count == COUNT_MAX && !cnt_wr
        |=> st_ff.flags[OVF_BIT] && st_ff.count == COUNT_BOTTOM)
        else $error("normal mode missed overflow");
    AST_PHASE_TURN: assert property (
        tick && phase && !st_ff.down && at_top && !cnt_wr
        |=> st_ff.down && st_ff.count == $past(st_ff.count) - 8'h01)
        else $error("phase mode did not reverse at top");
    AST_CTC_CLEAR: assert property (
        tick && mode == WM_CTC && st_ff.count == st_ff.cmp_a && !cnt_wr
        |=> st_ff.count == COUNT_BOTTOM)
        else $error("clear on compare failed");
    AST_WRITE_SETS_BLOCK: assert property (
        cnt_wr |=> st_ff.block)
        else $error("count write did not arm the match block");
    // Block lasts until the next tick, however far the prescaler puts it
    AST_WRITE_BLOCKS: assert property (
        tick && st_ff.block && !st_ff.flags[CMPB_BIT] |=> !st_ff.flags[CMPB_BIT])
        else $error("match after count write");
    AST_FORCE_NO_FLAG: assert property (
        force_a && !match_a && !st_ff.flags[CMPA_BIT] |=> !st_ff.flags[CMPA_BIT])
        else $error("forced strobe raised a flag");
    AST_FORCE_PWM_OFF: assert property (
        pwm |-> !force_a && !force_b)
        else $error("force acted in PWM mode");
    AST_IRQ_GATED: assert property (
        irq_compare_a |-> $past(st_ff.flags[CMPA_BIT] && st_ff.irq_en[CMPA_BIT]
                                && global_irq_enable))
        else $error("interrupt without enable and flag");
    AST_MATCH_SETS_FLAG: assert property (
        match_b |=> st_ff.flags[CMPB_BIT])
        else $error("compare B flag not set");

    CV_PHASE_BOTTOM: cover property (tick && phase && st_ff.down && st_ff.count == 8'h00);
    CV_CTC_WRAP: cover property (tick && mode == WM_CTC && at_top);
    CV_FORCE_A: cover property (force_a);
    CV_FAST_TOGGLE: cover property (mode == WM_FAST_A && match_a);

endmodule
`default_nettype wire

//--- verif/timer8_wavegen_tb.sv
// Self-checking testbench of the 8-bit timer with AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import timer8_pkg::*;
    logic              aclk;
    logic              aresetn;
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic              awready;
    logic [DATA_W-1:0] wdata;
    logic              wvalid;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready;
    logic              gie;
    logic              ack_ovf;
    logic              ack_a;
    logic              ack_b;
    logic              wave_a;
    logic              wave_b;
    logic              osc;
    logic [2:0]        irqs;
    logic [1:0]        rsp;
    logic [31:0]       rd;
    int                n_mismatch;
    int                check_count;
    int                cycles;

    timer8_wavegen i_timer8_wavegen (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .global_irq_enable(gie), .vector_ack_overflow(ack_ovf),
        .vector_ack_compare_a(ack_a), .vector_ack_compare_b(ack_b),
        .timer_source_clock(osc), .wave_out_a(wave_a), .wave_out_b(wave_b),
        .irq_overflow(irqs[0]), .irq_compare_a(irqs[1]), .irq_compare_b(irqs[2])
    );

    always #50 aclk = ~aclk;

    // Hang guard, well above the longest expected run
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Bus master: handshakes judged at the rising edge; bready and rready stay high
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        logic a_ok;
        logic w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        awaddr  <= {2'h0, idx, 2'h0};
        wdata   <= {24'h0, val};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                a_ok = 1'b1;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rsp = bresp;
    endtask

    task automatic rdr(input logic [7:0] idx);
        araddr  <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd  = rdata;
        rsp = rresp;
    endtask

    task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
        rdr(idx);
        check(rd, {24'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_map();
        rd_check(IDX_CTRL_B, RESET_BYTE);
        rd_check(IDX_IRQ_FLAGS, RESET_BYTE);
        rdr(8'hb5);
        check(rsp, RESP_SLVERR);
        wr(8'hb5, 8'hff);
        check(rsp, RESP_SLVERR);
        wr(IDX_CTRL_A, 8'h01);
        wr(IDX_CTRL_B, 8'h38);
        rd_check(IDX_CTRL_B, 8'h08);
        wr(IDX_CTRL_B, 8'h00);
        wr(IDX_CTRL_A, 8'h00);
        wr(IDX_COUNT, 8'h5a);
        repeat (20) @(posedge aclk);
        rd_check(IDX_COUNT, 8'h5a);
    endtask

    task automatic t_force();
        logic a0;
        logic b0;
        wr(IDX_IRQ_FLAGS, 8'h07);
        a0 = wave_a;
        b0 = wave_b;
        wr(IDX_CTRL_A, 8'h50);
        wr(IDX_CTRL_B, 8'hc0);
        repeat (2) @(posedge aclk);
        check({wave_a, wave_b}, {~a0, ~b0});
        rd_check(IDX_CTRL_B, 8'h00);
        rd_check(IDX_IRQ_FLAGS, 8'h00);
        wr(IDX_CTRL_A, 8'h00);
    endtask

    task automatic t_normal_flags();
        wr(IDX_CMP_A, 8'hf8);
        wr(IDX_CMP_B, 8'hfa);
        wr(IDX_COUNT, 8'hf0);
        wr(IDX_IRQ_EN, 8'h07);
        gie <= 1'b1;
        wr(IDX_CTRL_B, 8'h01);
        repeat (30) @(posedge aclk);
        wr(IDX_CTRL_B, 8'h00);
        rd_check(IDX_IRQ_FLAGS, 8'h07);
        check(irqs, 3'h7);
        wr(IDX_IRQ_FLAGS, 8'h01);
        rd_check(IDX_IRQ_FLAGS, 8'h06);
        ack_a <= 1'b1;
        @(posedge aclk);
        ack_a <= 1'b0;
        rd_check(IDX_IRQ_FLAGS, 8'h04);
        gie <= 1'b0;
        repeat (2) @(posedge aclk);
        check(irqs, 3'h0);
        wr(IDX_IRQ_FLAGS, 8'h07);
    endtask

    task automatic t_prescale();
        int div [6];
        div = '{8, 32, 64, 128, 256, 1024};
        for (int i = 0; i < 6; i++) begin
            wr(IDX_COUNT, 8'h00);
            wr(IDX_CTRL_B, 8'(i + 2));
            repeat (10 * div[i]) @(posedge aclk);
            wr(IDX_CTRL_B, 8'h00);
            rdr(IDX_COUNT);
            check(32'(rd >= 9 && rd <= 11), 32'h1);
        end
    endtask

    task automatic t_phase();
        wr(IDX_CTRL_A, 8'h01);
        wr(IDX_IRQ_FLAGS, 8'h07);
        wr(IDX_COUNT, 8'hf8);
        wr(IDX_CTRL_B, 8'h01);
        repeat (20) @(posedge aclk);
        wr(IDX_CTRL_B, 8'h00);
        rdr(IDX_COUNT);
        check(32'(rd >= 32'he0 && rd < 32'hff), 32'h1);
        rdr(IDX_IRQ_FLAGS);
        check(32'(rd[OVF_BIT]), 32'h0);
        wr(IDX_CTRL_B, 8'h01);
        repeat (300) @(posedge aclk);
        wr(IDX_CTRL_B, 8'h00);
        rdr(IDX_IRQ_FLAGS);
        check(32'(rd[OVF_BIT]), 32'h1);
    endtask

    // Compare A as top; overflow only where the mode flags it at top
    task automatic t_top(input logic [7:0] ma, input logic [7:0] mb, input logic ovf);
        wr(IDX_CTRL_A, ma);
        wr(IDX_CTRL_B, mb);
        wr(IDX_CMP_A, 8'h10);
        wr(IDX_IRQ_FLAGS, 8'h07);
        wr(IDX_COUNT, 8'h00);
        wr(IDX_CTRL_B, mb | 8'h01);
        repeat (100) @(posedge aclk);
        wr(IDX_CTRL_B, mb);
        rdr(IDX_COUNT);
        check(32'(rd <= 32'h10), 32'h1);
        rdr(IDX_IRQ_FLAGS);
        check(32'(rd[OVF_BIT]), 32'(ovf));
        wr(IDX_CTRL_B, 8'h00);
        wr(IDX_CTRL_A, 8'h00);
    endtask

    task automatic t_write_blocks();
        wr(IDX_CMP_B, 8'h30);
        wr(IDX_COUNT, 8'h00);
        wr(IDX_IRQ_FLAGS, 8'h07);
        wr(IDX_CTRL_B, 8'h01);
        wr(IDX_COUNT, 8'h30);
        wr(IDX_CTRL_B, 8'h00);
        rdr(IDX_IRQ_FLAGS);
        check(32'(rd[CMPB_BIT]), 32'h0);
    endtask

    // Pin clock: ten slow rising edges give exactly ten counts
    task automatic t_async();
        wr(IDX_CLK_SRC, 8'h20);
        rd_check(IDX_CLK_SRC, 8'h20);
        wr(IDX_COUNT, 8'h00);
        wr(IDX_CTRL_B, 8'h01);
        repeat (10) begin
            osc <= 1'b1;
            repeat (4) @(posedge aclk);
            osc <= 1'b0;
            repeat (4) @(posedge aclk);
        end
        wr(IDX_CTRL_B, 8'h00);
        rd_check(IDX_COUNT, 8'h0a);
        wr(IDX_CLK_SRC, 8'h00);
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, gie, ack_ovf, ack_a, ack_b, osc} = '0;
        n_mismatch = 0;
        check_count = 0;
        cycles = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        bready  <= 1'b1;
        rready  <= 1'b1;
        t_reset_and_map();
        t_force();
        t_normal_flags();
        t_prescale();
        t_phase();
        t_top(8'h02, 8'h00, 1'b0);
        t_top(8'h03, 8'h08, 1'b1);
        t_write_blocks();
        t_async();
        final_report();
    end
endmodule
`default_nettype wire
